// File: pwm_timing_pkg.sv
/*
 * Shared constants for the three-phase centre-based PWM timing unit:
 * field widths, register select codes, bit positions, reset values and states.
 * Assumes a single 25 MHz core clock and synchronous, active-low reset.
 */
package pwm_timing_pkg;

	localparam int PERIOD_W = 16;
	localparam int DEAD_W   = 10;
	localparam int DUTY_W   = 16;
	localparam int CTRL_W   = 16;
	localparam int MASK_W   = 9;
	localparam int SEL_W    = 3;
	localparam int PHASES   = 3;
	localparam int LEAD_W   = PERIOD_W + 2;

	localparam real CLK_PERIOD_NS = 40.0;

	// Register select codes on the write port.
	localparam logic [SEL_W-1:0] SEL_HALF_PERIOD = 3'h0;
	localparam logic [SEL_W-1:0] SEL_DEAD_TIME   = 3'h1;
	localparam logic [SEL_W-1:0] SEL_DUTY0       = 3'h2;
	localparam logic [SEL_W-1:0] SEL_DUTY1       = 3'h3;
	localparam logic [SEL_W-1:0] SEL_DUTY2       = 3'h4;
	localparam logic [SEL_W-1:0] SEL_CONTROL     = 3'h5;
	localparam logic [SEL_W-1:0] SEL_MASK        = 3'h6;

	// Field positions.
	localparam int CTRL_DOUBLE_BIT = 2;
	localparam int STATUS_HALF_BIT = 0;
	localparam int MASK_CROSS_BASE = 6;
	localparam int MASK_DIS_TOP    = 5;

	// Reset values.
	localparam logic [PERIOD_W-1:0] HALF_PERIOD_RESET = 16'h0000;
	localparam logic [DEAD_W-1:0]   DEAD_TIME_RESET   = 10'h000;
	localparam logic [DUTY_W-1:0]   DUTY_RESET        = 16'h0000;
	localparam logic [CTRL_W-1:0]   CONTROL_RESET     = 16'h0000;
	localparam logic [MASK_W-1:0]   MASK_RESET        = 9'h000;
	localparam logic [LEAD_W-1:0]   LEAD_ZERO         = 18'h00000;
	localparam logic [PERIOD_W-1:0] COUNT_ZERO        = 16'h0000;
	localparam logic [PERIOD_W-1:0] COUNT_ONE         = 16'h0001;
	localparam logic [LEAD_W-1:0]   LEAD_ONE          = 18'h00001;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b001,
		ST_PRESTART = 3'b010,
		ST_RUN      = 3'b100
	} timer_state_t;

endpackage

// File: phase_pair_edges.sv
/*
 * Combinational edge placement for one complementary phase pair.
 * Assumes the caller supplies the latched half-period, duty and dead-time
 * values and the position within the current half period.
 */
`timescale 1ns/1ps
module phase_pair_edges
#(
	parameter int CW = pwm_timing_pkg::PERIOD_W,
	parameter int DW = pwm_timing_pkg::DEAD_W
)
(
	input  wire logic [CW-1:0] half_in,
	input  wire logic [CW-1:0] count_in,
	input  wire logic [CW-1:0] duty_in,
	input  wire logic [DW-1:0] dead_in,
	input  wire logic          second_half_in,
	output logic               high_out,
	output logic               low_out
);
	import pwm_timing_pkg::*;

	logic signed [CW+2:0] centre;
	logic signed [CW+2:0] pos;
	logic signed [CW+2:0] duty_s;
	logic signed [CW+2:0] dead_s;
	logic signed [CW+2:0] edge_high;
	logic signed [CW+2:0] edge_low;

	// Signed compares clamp naturally: an edge before zero or past the half
	// holds the output on or off for the whole half.
	always_comb
	begin
		centre = $signed({3'b000, 1'b0, half_in[CW-1:1]});
		pos    = $signed({3'b000, count_in});
		duty_s = $signed({3'b000, duty_in});
		dead_s = $signed({{(CW+3-DW){1'b0}}, dead_in});
		if (!second_half_in)
		begin
			edge_high = centre - duty_s + dead_s;
			edge_low  = centre - duty_s - dead_s;
			high_out  = (pos >= edge_high);
			low_out   = (pos < edge_low);
		end
		else
		begin
			edge_high = centre + duty_s - dead_s;
			edge_low  = centre + duty_s + dead_s;
			high_out  = (pos < edge_high);
			low_out   = (pos >= edge_low);
		end
	end

endmodule

// File: pwm_timing_unit.sv
/*
 * Three-phase centre-based PWM timing unit with shared dead time,
 * single or double update mode, period sync pulse and half-cycle status.
 * Assumes software writes registers through the select/data write port,
 * synchronous to clk_in, and never programs a half period below two.
 */
// Behaviour
// - Ten-bit dead time inserts value times two clocks between complementary edges.
// - One dead-time setting serves all three phase pairs alike.
// - Dead time accepts zero through 0x3FF in two-clock steps.
// - Control bit 2 picks double update; reset leaves single update.
// - Single mode: one sync per period starts it and loads timing values.
// - Sync also loads output enables and crossover into the output stage.
// - Double mode adds a mid-period sync that reloads all values.
// - Status bit 0 is zero in first half, one in second.
// - Three 16-bit duty registers give high-side on time per half.
// - Outputs are active high; high commands the switch on.
// - Dead time shifts both edges equally away from the duty instant.
// - On times saturate between zero and the full period.
// - In double mode each half uses its own latched values; period is their sum.
// - No outputs or counting until period and all duties are written.
// - Period write starts the timer; first sync after 1.5 (single) or 1 (double) half periods.
// - Period register holds clock cycles in one half period.
// - An interrupt request accompanies every sync pulse.
`timescale 1ns/1ps
module pwm_timing_unit
#(
	parameter int PW = pwm_timing_pkg::PERIOD_W,
	parameter int DW = pwm_timing_pkg::DEAD_W
)
(
	input  wire logic                             clk_in,
	input  wire logic                             rst_n_in,
	input  wire logic                             wr_en_in,
	input  wire logic [pwm_timing_pkg::SEL_W-1:0] wr_sel_in,
	input  wire logic [PW-1:0]                    wr_data_in,
	output logic [PW-1:0]                         half_period_count_out,
	output logic [DW-1:0]                         dead_time_length_out,
	output logic [pwm_timing_pkg::DUTY_W-1:0]     phase0_duty_out,
	output logic [pwm_timing_pkg::DUTY_W-1:0]     phase1_duty_out,
	output logic [pwm_timing_pkg::DUTY_W-1:0]     phase2_duty_out,
	output logic [pwm_timing_pkg::CTRL_W-1:0]     generator_control_out,
	output logic [pwm_timing_pkg::MASK_W-1:0]     output_mask_out,
	output logic                                  half_cycle_out,
	output logic                                  period_sync_pulse_out,
	output logic                                  sync_irq_out,
	output logic [pwm_timing_pkg::PHASES-1:0]     high_side_out,
	output logic [pwm_timing_pkg::PHASES-1:0]     low_side_out
);
	import pwm_timing_pkg::*;

	// Software-visible shadow registers.
	logic [PW-1:0]     half_period_reg;
	logic [PW-1:0]     half_period_next;
	logic [DW-1:0]     dead_time_reg;
	logic [DW-1:0]     dead_time_next;
	logic [DUTY_W-1:0] duty_reg [PHASES];
	logic [DUTY_W-1:0] duty_next [PHASES];
	logic [CTRL_W-1:0] control_reg;
	logic [CTRL_W-1:0] control_next;
	logic [MASK_W-1:0] mask_reg;
	logic [MASK_W-1:0] mask_next;
	logic [3:0]        written_reg;
	logic [3:0]        written_next;

	// Timing state and working copies.
	timer_state_t      state_reg;
	timer_state_t      state_next;
	logic [LEAD_W-1:0] lead_reg;
	logic [LEAD_W-1:0] lead_next;
	logic [PW-1:0]     count_reg;
	logic [PW-1:0]     count_next;
	logic              second_reg;
	logic              second_next;
	logic              sync_reg;
	logic              sync_next;
	logic [PW-1:0]     work_half_reg;
	logic [PW-1:0]     work_half_next;
	logic [DW-1:0]     work_dead_reg;
	logic [DW-1:0]     work_dead_next;
	logic [DUTY_W-1:0] work_duty_reg [PHASES];
	logic [DUTY_W-1:0] work_duty_next [PHASES];
	logic [MASK_W-1:0] work_mask_reg;
	logic [MASK_W-1:0] work_mask_next;
	logic [PHASES-1:0] high_reg;
	logic [PHASES-1:0] high_next;
	logic [PHASES-1:0] low_reg;
	logic [PHASES-1:0] low_next;

	logic [PHASES-1:0] raw_high;
	logic [PHASES-1:0] raw_low;
	logic              double_mode;
	logic              all_written;
	logic              take_sync;
	logic [LEAD_W-1:0] wr_lead;

	function automatic logic sel_hit(input logic [SEL_W-1:0] code);
		sel_hit = wr_en_in && (wr_sel_in == code);
	endfunction

	assign double_mode = control_reg[CTRL_DOUBLE_BIT];
	assign all_written = &written_reg;

	// Lead from the period write to the first sync: 1.5 halves in single
	// mode, one half in double mode.
	always_comb
	begin
		if (double_mode)
			wr_lead = {2'b00, wr_data_in};
		else
			wr_lead = {2'b00, wr_data_in} + {3'b000, wr_data_in[PW-1:1]};
	end

	// Register file.
	always_comb
	begin
		half_period_next = half_period_reg;
		dead_time_next   = dead_time_reg;
		control_next     = control_reg;
		mask_next        = mask_reg;
		written_next     = written_reg;
		for (int i = 0; i < PHASES; i++)
			duty_next[i] = duty_reg[i];
		if (sel_hit(SEL_HALF_PERIOD))
		begin
			half_period_next = wr_data_in;
			written_next[0]  = 1'b1;
		end
		if (sel_hit(SEL_DEAD_TIME))
			dead_time_next = wr_data_in[DW-1:0];
		for (int i = 0; i < PHASES; i++)
		begin
			if (sel_hit(SEL_DUTY0 + SEL_W'(i)))
			begin
				duty_next[i]       = wr_data_in;
				written_next[i+1]  = 1'b1;
			end
		end
		if (sel_hit(SEL_CONTROL))
			control_next = wr_data_in;
		if (sel_hit(SEL_MASK))
			mask_next = wr_data_in[MASK_W-1:0];
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			half_period_reg <= HALF_PERIOD_RESET;
			dead_time_reg   <= DEAD_TIME_RESET;
			control_reg     <= CONTROL_RESET;
			mask_reg        <= MASK_RESET;
			written_reg     <= 4'h0;
			for (int i = 0; i < PHASES; i++)
				duty_reg[i] <= DUTY_RESET;
		end
		else
		begin
			half_period_reg <= half_period_next;
			dead_time_reg   <= dead_time_next;
			control_reg     <= control_next;
			mask_reg        <= mask_next;
			written_reg     <= written_next;
			for (int i = 0; i < PHASES; i++)
				duty_reg[i] <= duty_next[i];
		end
	end

	// The same dead time feeds every pair.
	genvar g;
	generate
		for (g = 0; g < PHASES; g++)
		begin : pair
			phase_pair_edges #(
				.CW(PW),
				.DW(DW)
			) edges (
				.half_in        (work_half_reg),
				.count_in       (count_reg),
				.duty_in        (work_duty_reg[g]),
				.dead_in        (work_dead_reg),
				.second_half_in (second_reg),
				.high_out       (raw_high[g]),
				.low_out        (raw_low[g])
			);
		end
	endgenerate

	// Timing sequencer.
	always_comb
	begin
		state_next     = state_reg;
		lead_next      = lead_reg;
		count_next     = count_reg;
		second_next    = second_reg;
		sync_next      = 1'b0;
		take_sync      = 1'b0;
		work_half_next = work_half_reg;
		work_dead_next = work_dead_reg;
		work_mask_next = work_mask_reg;
		for (int i = 0; i < PHASES; i++)
			work_duty_next[i] = work_duty_reg[i];
		case (state_reg)
			ST_IDLE:
			begin
				if (sel_hit(SEL_HALF_PERIOD))
				begin
					state_next = ST_PRESTART;
					lead_next  = wr_lead - LEAD_ONE;
				end
			end
			ST_PRESTART:
			begin
				if (lead_reg != LEAD_ZERO)
					lead_next = lead_reg - LEAD_ONE;
				else if (all_written)
				begin
					take_sync   = 1'b1;
					state_next  = ST_RUN;
					count_next  = COUNT_ZERO;
					second_next = 1'b0;
				end
			end
			ST_RUN:
			begin
				if (count_reg >= work_half_reg - COUNT_ONE)
				begin
					count_next = COUNT_ZERO;
					if (!second_reg)
					begin
						second_next = 1'b1;
						take_sync   = double_mode;
					end
					else
					begin
						second_next = 1'b0;
						take_sync   = 1'b1;
					end
				end
				else
					count_next = count_reg + COUNT_ONE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
		// A sync loads the values that govern the half now starting.
		if (take_sync)
		begin
			sync_next      = 1'b1;
			work_half_next = half_period_reg;
			work_dead_next = dead_time_reg;
			work_mask_next = mask_reg;
			for (int i = 0; i < PHASES; i++)
				work_duty_next[i] = duty_reg[i];
		end
	end

	// Output stage: crossover first, then per-output disable; off is low.
	always_comb
	begin
		for (int i = 0; i < PHASES; i++)
		begin
			if (state_reg != ST_RUN)
			begin
				high_next[i] = 1'b0;
				low_next[i]  = 1'b0;
			end
			else if (work_mask_reg[MASK_CROSS_BASE + PHASES - 1 - i])
			begin
				high_next[i] = raw_low[i] && !work_mask_reg[MASK_DIS_TOP - 2*i];
				low_next[i]  = raw_high[i] && !work_mask_reg[MASK_DIS_TOP - 2*i - 1];
			end
			else
			begin
				high_next[i] = raw_high[i] && !work_mask_reg[MASK_DIS_TOP - 2*i];
				low_next[i]  = raw_low[i] && !work_mask_reg[MASK_DIS_TOP - 2*i - 1];
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_reg     <= ST_IDLE;
			lead_reg      <= LEAD_ZERO;
			count_reg     <= COUNT_ZERO;
			second_reg    <= 1'b0;
			sync_reg      <= 1'b0;
			work_half_reg <= HALF_PERIOD_RESET;
			work_dead_reg <= DEAD_TIME_RESET;
			work_mask_reg <= MASK_RESET;
			high_reg      <= '0;
			low_reg       <= '0;
			for (int i = 0; i < PHASES; i++)
				work_duty_reg[i] <= DUTY_RESET;
		end
		else
		begin
			state_reg     <= state_next;
			lead_reg      <= lead_next;
			count_reg     <= count_next;
			second_reg    <= second_next;
			sync_reg      <= sync_next;
			work_half_reg <= work_half_next;
			work_dead_reg <= work_dead_next;
			work_mask_reg <= work_mask_next;
			high_reg      <= high_next;
			low_reg       <= low_next;
			for (int i = 0; i < PHASES; i++)
				work_duty_reg[i] <= work_duty_next[i];
		end
	end

	assign half_period_count_out = half_period_reg;
	assign dead_time_length_out  = dead_time_reg;
	assign phase0_duty_out       = duty_reg[0];
	assign phase1_duty_out       = duty_reg[1];
	assign phase2_duty_out       = duty_reg[2];
	assign generator_control_out = control_reg;
	assign output_mask_out       = mask_reg;
	assign half_cycle_out        = second_reg;
	assign period_sync_pulse_out = sync_reg;
	assign sync_irq_out          = sync_reg;
	assign high_side_out         = high_reg;
	assign low_side_out          = low_reg;

endmodule

// File: pwm_timing_unit_assertions.sv
/*
 * Concurrent checks on the ports of the PWM timing unit.
 * Assumes it is bound onto the unit, one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module pwm_timing_unit_assertions
#(
	parameter int PW = pwm_timing_pkg::PERIOD_W,
	parameter int DW = pwm_timing_pkg::DEAD_W
)
(
	input  wire logic                              clk_in,
	input  wire logic                              rst_n_in,
	input  wire logic                              wr_en_in,
	input  wire logic [pwm_timing_pkg::SEL_W-1:0]  wr_sel_in,
	input  wire logic [PW-1:0]                     wr_data_in,
	input  wire logic [PW-1:0]                     half_period_count_out,
	input  wire logic [DW-1:0]                     dead_time_length_out,
	input  wire logic [pwm_timing_pkg::DUTY_W-1:0] phase0_duty_out,
	input  wire logic [pwm_timing_pkg::CTRL_W-1:0] generator_control_out,
	input  wire logic                              half_cycle_out,
	input  wire logic                              period_sync_pulse_out,
	input  wire logic                              sync_irq_out,
	input  wire logic [pwm_timing_pkg::PHASES-1:0] high_side_out,
	input  wire logic [pwm_timing_pkg::PHASES-1:0] low_side_out
);
	import pwm_timing_pkg::*;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	logic [PW+1:0] gap;
	logic          seen;
	logic [3:0]    wrote;
	logic          dbl;

	assign dbl = generator_control_out[CTRL_DOUBLE_BIT];

	// The first sync has no predecessor, so the spacing checks wait for the second.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			gap <= '0;
			seen <= 1'b0;
			wrote <= 4'h0;
		end
		else
		begin
			gap <= period_sync_pulse_out ? (PW+2)'(1) : gap + 1'b1;
			seen <= seen | period_sync_pulse_out;
			wrote[0] <= wrote[0] | (wr_en_in && wr_sel_in == SEL_HALF_PERIOD);
			wrote[1] <= wrote[1] | (wr_en_in && wr_sel_in == SEL_DUTY0);
			wrote[2] <= wrote[2] | (wr_en_in && wr_sel_in == SEL_DUTY1);
			wrote[3] <= wrote[3] | (wr_en_in && wr_sel_in == SEL_DUTY2);
		end
	end

	sequence s_one_cycle;
		period_sync_pulse_out ##1 !period_sync_pulse_out;
	endsequence
	sequence s_dead_wr;
		wr_en_in && wr_sel_in == SEL_DEAD_TIME;
	endsequence

	property p_irq_copy;
		sync_irq_out == period_sync_pulse_out;
	endproperty
	property p_sync_width;
		$rose(period_sync_pulse_out) |-> s_one_cycle;
	endproperty
	property p_half_first;
		period_sync_pulse_out && !dbl |-> !half_cycle_out;
	endproperty
	property p_half_mid;
		$changed(half_cycle_out) && dbl |-> period_sync_pulse_out;
	endproperty
	property p_gap_single;
		seen && period_sync_pulse_out && !dbl |-> gap == {1'b0, half_period_count_out, 1'b0};
	endproperty
	property p_gap_double;
		seen && period_sync_pulse_out && dbl |-> gap == {2'b00, half_period_count_out};
	endproperty
	property p_idle;
		wrote != 4'hF |-> high_side_out == '0 && low_side_out == '0 && !period_sync_pulse_out;
	endproperty
	property p_no_overlap;
		(high_side_out & low_side_out) == '0;
	endproperty
	property p_dead_rb;
		logic [DW-1:0] d;
		(s_dead_wr, d = wr_data_in[DW-1:0]) |=> dead_time_length_out == d;
	endproperty
	property p_duty_rb;
		logic [DUTY_W-1:0] v;
		(wr_en_in && wr_sel_in == SEL_DUTY0, v = wr_data_in) |=> phase0_duty_out == v;
	endproperty
	property p_mode_reset;
		$rose(rst_n_in) |-> !dbl;
	endproperty

	a_irq_copy: assert property (p_irq_copy) else $error("irq differs from sync");
	a_sync_width: assert property (p_sync_width) else $error("sync not one cycle");
	a_half_first: assert property (p_half_first) else $error("half flag set at start");
	a_half_mid: assert property (p_half_mid) else $error("half flag moved without sync");
	a_gap_single: assert property (p_gap_single) else $error("single sync spacing");
	a_gap_double: assert property (p_gap_double) else $error("double sync spacing");
	a_idle: assert property (p_idle) else $error("activity before start");
	a_no_overlap: assert property (p_no_overlap) else $error("pair both on");
	a_dead_rb: assert property (p_dead_rb) else $error("dead time readback");
	a_duty_rb: assert property (p_duty_rb) else $error("duty readback");
	a_mode_reset: assert property (p_mode_reset) else $error("mode after reset");
endmodule

// File: gate_driver_model.sv
/*
 * Behavioural gate-driver stage: counts on-time of each switch per sync window.
 * Assumes the sync pulse marks window boundaries and outputs are active high.
 */
`timescale 1ns/1ps
module gate_driver_model
(
	input  wire logic                              clk_in,
	input  wire logic                              sync_in,
	input  wire logic [pwm_timing_pkg::PHASES-1:0] high_in,
	input  wire logic [pwm_timing_pkg::PHASES-1:0] low_in,
	output logic [7:0]                             hi_on_out [pwm_timing_pkg::PHASES],
	output logic [7:0]                             lo_on_out [pwm_timing_pkg::PHASES],
	output logic [7:0]                             overlap_out
);
	import pwm_timing_pkg::*;

	logic [7:0] hi_acc [PHASES];
	logic [7:0] lo_acc [PHASES];

	initial overlap_out = 8'h00;

	// A high level turns the switch on; both on in one leg would short the link.
	always @(posedge clk_in)
	begin
		if ((high_in & low_in) != '0)
			overlap_out <= overlap_out + 8'h01;
		for (int i = 0; i < PHASES; i++)
		begin
			if (sync_in)
			begin
				hi_on_out[i] <= hi_acc[i];
				lo_on_out[i] <= lo_acc[i];
				hi_acc[i] <= {7'h00, high_in[i]};
				lo_acc[i] <= {7'h00, low_in[i]};
			end
			else
			begin
				hi_acc[i] <= hi_acc[i] + {7'h00, high_in[i]};
				lo_acc[i] <= lo_acc[i] + {7'h00, low_in[i]};
			end
		end
	end
endmodule

// File: test_pwm_timing_unit.sv
/*
 * Self-checking bench for the PWM timing unit with a gate-driver model.
 * Assumes a 25 MHz clock and inputs driven on the falling edge.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module test_pwm_timing_unit;
	import pwm_timing_pkg::*;
	localparam int P = 8;
	logic             clk_in = 1'b0;
	logic             rst_n = 1'b0;
	logic             wr_en = 1'b0;
	logic [SEL_W-1:0] sel = 3'h0;
	logic [15:0]      data = 16'h0000;
	logic [15:0]      hp, d0, d1, d2, ctrl;
	logic [9:0]       dt;
	logic [8:0]       mask;
	logic             half, sync, irq;
	logic [2:0]       hs, ls;
	logic [7:0]       hon [PHASES];
	logic [7:0]       lon [PHASES];
	logic [7:0]       ovl;
	int               n_mismatch = 0, n_checks = 0, cyc = 0, n;
	int               duty [PHASES] = '{2, 3, 0};

	pwm_timing_unit dut_u (.clk_in(clk_in), .rst_n_in(rst_n), .wr_en_in(wr_en),
		.wr_sel_in(sel), .wr_data_in(data), .half_period_count_out(hp),
		.dead_time_length_out(dt), .phase0_duty_out(d0), .phase1_duty_out(d1),
		.phase2_duty_out(d2), .generator_control_out(ctrl), .output_mask_out(mask),
		.half_cycle_out(half), .period_sync_pulse_out(sync), .sync_irq_out(irq),
		.high_side_out(hs), .low_side_out(ls));
	gate_driver_model drv_u (.clk_in(clk_in), .sync_in(sync), .high_in(hs), .low_in(ls),
		.hi_on_out(hon), .lo_on_out(lon), .overlap_out(ovl));

	always #20 clk_in = ~clk_in;

	function automatic logic [7:0] clip(input int v);
		return (v < 0) ? 8'h00 : (v > 2 * P) ? 8'(2 * P) : 8'(v);
	endfunction

	task automatic give_verdict;
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (6) @(negedge clk_in);
		rst_n = 1'b1;
	endtask

	// Leaves one idle cycle so the strobe is never lowered and raised in one step.
	task automatic wr(input logic [SEL_W-1:0] s, input logic [15:0] d);
		wr_en = 1'b1;
		sel = s;
		data = d;
		@(negedge clk_in);
		wr_en = 1'b0;
		@(negedge clk_in);
	endtask

	task automatic wait_sync(output int k);
		k = 0;
		do
		begin
			@(negedge clk_in);
			k++;
		end
		while (sync !== 1'b1 && k < 60);
	endtask

	task automatic syncs(input int k);
		repeat (k) wait_sync(n);
		@(negedge clk_in);
	endtask

	task automatic write_duties;
		for (int i = 0; i < PHASES; i++)
			wr(SEL_W'(SEL_DUTY0 + i), 16'(duty[i]));
	endtask

	initial
	begin
		do_reset();
		`CHK({ctrl, dt, mask, half, sync, hs, ls}, '0)
		wr(SEL_DEAD_TIME, 16'hFC01);
		`CHK(dt, 10'h001)
		write_duties();
		`CHK({d0, d1, d2}, {16'(duty[0]), 16'(duty[1]), 16'(duty[2])})
		wait_sync(n);
		`CHK(n, 60)
		`CHK({hs, ls}, 6'h00)
		wr(SEL_HALF_PERIOD, 16'(P));
		wait_sync(n);
		`CHK(n + 1, 3 * P / 2)
		`CHK(half, 1'b0)
		`CHK(hp, 16'(P))
		repeat (P) @(negedge clk_in);
		`CHK(half, 1'b1)
		wait_sync(n);
		`CHK(n, P)
		syncs(1);
		for (int i = 0; i < PHASES; i++)
		begin
			`CHK(hon[i], clip(P + 2 * (duty[i] - 1)))
			`CHK(lon[i], clip(P - 2 * (duty[i] + 1)))
		end
		wr(SEL_DUTY0, 16'h0006);
		wr(SEL_DEAD_TIME, 16'h0000);
		wr(SEL_MASK, 16'h0108);
		`CHK(mask, 9'h108)
		syncs(3);
		`CHK({hon[0], lon[0]}, {8'h00, clip(P + 12)})
		`CHK({hon[1], lon[1]}, {8'h00, clip(P - 6)})
		`CHK({hon[2], lon[2]}, {8'(P), 8'(P)})
		wr(SEL_DEAD_TIME, 16'h03FF);
		`CHK(dt, 10'h3FF)
		wr(SEL_MASK, 16'h0000);
		syncs(3);
		for (int i = 0; i < PHASES; i++)
			`CHK({hon[i], lon[i]}, 16'h0000)
		`CHK(ovl, 8'h00)
		do_reset();
		wr(SEL_CONTROL, 16'h0004);
		`CHK(ctrl[CTRL_DOUBLE_BIT], 1'b1)
		write_duties();
		wr(SEL_HALF_PERIOD, 16'(P));
		wait_sync(n);
		`CHK(n + 1, P)
		for (int k = 0; k < 4; k++)
		begin
			`CHK(half, k[0])
			`CHK(irq, 1'b1)
			wait_sync(n);
			`CHK(n, P)
		end
		// A reset taken in double mode must fall back to single update.
		do_reset();
		`CHK({ctrl, half, sync, hs, ls}, '0)
		give_verdict();
	end
endmodule

bind pwm_timing_unit pwm_timing_unit_assertions #(.PW(PW), .DW(DW)) chk_u (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in),
	.wr_data_in(wr_data_in), .half_period_count_out(half_period_count_out),
	.dead_time_length_out(dead_time_length_out), .phase0_duty_out(phase0_duty_out),
	.generator_control_out(generator_control_out), .half_cycle_out(half_cycle_out),
	.period_sync_pulse_out(period_sync_pulse_out), .sync_irq_out(sync_irq_out),
	.high_side_out(high_side_out), .low_side_out(low_side_out));
